// *** bench/fetc_mac_model.sv ***
// mac model presenting preamble then counting data nibbles on the transmit side
`timescale 1ns/10ps
module fetc_mac_model
    import fetc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       go_i,
    input  wire logic [4:0] len_i,
    input  wire logic       take_i,
    output fetc_tx_mii_s    tx_mii_o
);
    logic [5:0] idx_reg;
    logic [5:0] idx_next;
    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        idx_next = idx_reg;
        if (!go_i) begin
            idx_next = 6'h00;
        end else if (take_i) begin
            idx_next = idx_reg + 6'h01;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            idx_reg <= 6'h00;
        end else begin
            idx_reg <= idx_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        tx_mii_o.en = go_i && (idx_reg < 6'(len_i) + 6'h02);
        if (!tx_mii_o.en) begin
            tx_mii_o.data = ~idx_reg[3:0]; // idle lines carry the inverted index nibble, which holds while go is high and turns to all ones once go drops and clears the index
        end else if (idx_reg < 6'h02) begin
            tx_mii_o.data = NIB_SSD;
        end else begin
            tx_mii_o.data = 4'(idx_reg - 6'h02);
        end
    end
endmodule // fetc_mac_model

// *** bench/fetc_path_properties.sv ***
// port-level timing checker for the coding path, bound to its top module
`timescale 1ns/10ps
module fetc_path_chk
    import fetc_pkg::*;
#(
    parameter int BIT_DIV = BIT_DIV_DEF
) (
    input wire logic         core_clk_i,
    input wire logic         reset_n_i,
    input wire fetc_tx_mii_s tx_mii_i,
    input wire logic         tx_nibble_take_o,
    input wire fetc_mlt_s    tx_mlt_o,
    input wire fetc_rx_mii_s rx_mii_o,
    input wire logic         rx_nibble_vld_o
);
    localparam int GAP = 5 * BIT_DIV;
    localparam int GM1 = GAP - 1;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_mlt_excl; !(tx_mlt_o.pos && tx_mlt_o.neg); endproperty
    a_mlt_excl: assert property (p_mlt_excl) else $error("both drive streams high");
    property p_pos_next; tx_mlt_o.pos |=> !tx_mlt_o.neg; endproperty
    a_pos_next: assert property (p_pos_next) else $error("plus level jumped to minus");
    property p_neg_next; tx_mlt_o.neg |=> !tx_mlt_o.pos; endproperty
    a_neg_next: assert property (p_neg_next) else $error("minus level jumped to plus");
    property p_take_min; tx_nibble_take_o |=> !tx_nibble_take_o [*4]; endproperty
    a_take_min: assert property (p_take_min) else $error("nibble takes closer than a code-group");
    property p_take_en; tx_nibble_take_o |-> tx_mii_i.en; endproperty
    a_take_en: assert property (p_take_en) else $error("nibble taken while enable low");
    // a frame in flight must take one nibble per code-group, no gaps
    property p_take_exact; tx_nibble_take_o ##1 tx_mii_i.en |-> ##GM1 tx_nibble_take_o; endproperty
    a_take_exact: assert property (p_take_exact) else $error("nibble take missing in frame");
    property p_en_start; $rose(tx_mii_i.en) |-> ##[0:GAP] tx_nibble_take_o; endproperty
    a_en_start: assert property (p_en_start) else $error("frame start not taken in a code-group");
    property p_rx_space; rx_nibble_vld_o |=> !rx_nibble_vld_o [*4]; endproperty
    a_rx_space: assert property (p_rx_space) else $error("receive nibbles closer than a code-group");
    ////////////////////////////////////////////////////////////////////////////////
    c_take: cover property (tx_nibble_take_o);
    c_err:  cover property (rx_nibble_vld_o && rx_mii_o.er);
    c_ssd:  cover property (rx_nibble_vld_o && rx_mii_o.dv && rx_mii_o.data == NIB_SSD);
endmodule // fetc_path_chk

bind fetc_coding_path fetc_path_chk #(.BIT_DIV(BIT_DIV)) u_chk (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .tx_mii_i(tx_mii_i),
    .tx_nibble_take_o(tx_nibble_take_o), .tx_mlt_o(tx_mlt_o), .rx_mii_o(rx_mii_o),
    .rx_nibble_vld_o(rx_nibble_vld_o)
);

// *** bench/tb.sv ***
// self-checking bench: seed, loopback frames and receive code-group errors
`timescale 1ns/10ps
module tb;
    import fetc_pkg::*;
    logic         core_clk;
    logic         reset_n;
    logic [4:0]   straps;
    logic         go;
    logic [4:0]   len;
    logic         loop;
    logic         resync;
    logic         take;
    logic         rx_vld;
    logic         rx_frame;
    fetc_tx_mii_s tx_mii;
    fetc_mlt_s    tx_mlt;
    fetc_mlt_s    rx_line;
    fetc_mlt_s    enc_mlt;
    fetc_rx_mii_s rx_mii;
    fetc_rx_mii_s rxq [$];
    bit           encq [$];
    logic [10:0]  es = 11'h7ff;
    logic [1:0]   ml = 2'h0;
    logic         eb;
    logic         key;
    int           bad_count = 0;
    int           cmp_count = 0;
    ////////////////////////////////////////////////////////////////////////////////
    fetc_coding_path #(.BIT_DIV(1)) DUT (
        .core_clk_i(core_clk), .reset_n_i(reset_n), .phy_address_straps_i(straps), .tx_mii_i(tx_mii),
        .tx_nibble_take_o(take), .tx_mlt_o(tx_mlt), .rx_mlt_i(rx_line), .rx_resync_i(resync),
        .rx_mii_o(rx_mii), .rx_nibble_vld_o(rx_vld), .rx_in_frame_o(rx_frame)
    );
    fetc_mac_model u_mac (
        .core_clk_i(core_clk), .reset_n_i(reset_n), .go_i(go), .len_i(len), .take_i(take), .tx_mii_o(tx_mii)
    );
    assign rx_line = loop ? tx_mlt : enc_mlt;
    assign enc_mlt = {ml == 2'h1, ml == 2'h3};
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // far-side line encoder: idle ones whenever nothing is queued
    always @(posedge core_clk) begin
        #1;
        eb = (encq.size() > 0) ? encq.pop_front() : 1'b1;
        key = es[LFSR_TAP_A] ^ es[LFSR_TAP_B];
        es = {es[9:0], key};
        if (eb ^ key) ml = ml + 2'h1;
    end
    always @(posedge core_clk) begin
        if (rx_vld && (rx_mii.dv || rx_mii.er)) rxq.push_back(rx_mii);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic send_cg(input logic [4:0] cg);
        for (int i = 4; i >= 0; i--) encq.push_back(cg[i]);
    endtask
    task automatic resync_idle;
        cyc(40);
        resync = 1'b1;
        cyc(1);
        resync = 1'b0;
        cyc(20);
        rxq.delete();
    endtask
    task results;
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // two resets mid-run with opposite straps: idle line must follow a model seeded from the straps
    task automatic seed_chk;
        logic [31:0] w [2];
        logic [31:0] x;
        logic [10:0] s;
        logic [1:0]  m;
        logic        k2;
        for (int k = 0; k < 2; k++) begin
            reset_n = 1'b0;
            straps = k ? 5'h1f : 5'h00;
            cyc(5);
            reset_n = 1'b1;
            s = {straps, SEED_LOW};
            m = 2'h0;
            for (int i = 0; i < 16; i++) begin
                w[k] = {w[k][29:0], tx_mlt};
                x = {x[29:0], m == 2'h1, m == 2'h3};
                // first edge after release only loads the seed; stepping starts at the second
                if (i > 0) begin
                    k2 = s[LFSR_TAP_A] ^ s[LFSR_TAP_B];
                    s = {s[9:0], k2};
                    m = m + {1'b0, ~k2};
                end
                cyc(1);
            end
            for (int b = 0; b < 4; b++) chk(w[k][b*8 +: 8], x[b*8 +: 8]);
        end
        chk(8'(w[0] != w[1]), 8'h01);
    endtask
    // transmit looped to receive: K gives 0101, then every data nibble in order
    task automatic tx_frame(input logic [4:0] n);
        int w;
        loop = 1'b1;
        resync_idle();
        len = n;
        go = 1'b1;
        for (w = 0; w < 500 && tx_mii.en; w++) cyc(1);
        for (w = 0; w < 100 && !rx_frame; w++) cyc(1);
        for (w = 0; w < 100 && rx_frame; w++) cyc(1);
        chk(8'(rx_frame), 8'h00);
        go = 1'b0;
        chk(8'(rxq.size() > int'(n)), 8'h01);
        for (int i = 0; i <= n && i < rxq.size(); i++)
            chk({rxq[i].dv, rxq[i].er, 2'b00, rxq[i].data}, {4'h8, (i == 0) ? NIB_SSD : 4'(i - 1)});
    endtask
    // J K A then one code under test; all but the last entry must flag an error
    task automatic rx_codes;
        logic [4:0] cg [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c,
                                CG_HALT, CG_IDLE, CG_J, CG_K, CG_R, DATA_CG[5]};
        logic ea;
        logic ee;
        logic fs;
        loop = 1'b0;
        for (int k = 0; k < 14; k++) begin
            resync_idle();
            send_cg(CG_J);
            send_cg(CG_K);
            send_cg(DATA_CG[10]);
            send_cg(cg[k]);
            send_cg(CG_T);
            send_cg(CG_R);
            cyc(60);
            ea = 1'b0;
            ee = 1'b0;
            fs = rxq.size() > 0 && rxq[0].data === NIB_SSD && rxq[0].er === 1'b0;
            foreach (rxq[i]) begin
                if (rxq[i].data === 4'ha && rxq[i].er === 1'b0) ea = 1'b1;
                if (rxq[i].er === 1'b1) ee = 1'b1;
            end
            chk({5'h00, fs, ea, ee}, {5'h00, 1'b1, 1'b1, k < 13});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        straps = 5'h0b;
        go = 1'b0;
        len = 5'h00;
        loop = 1'b1;
        resync = 1'b0;
        cyc(5);
        reset_n = 1'b1;
        cyc(2);
        seed_chk();
        tx_frame(5'h10);
        tx_frame(5'h01);
        rx_codes();
        results();
    end
    // the whole run needs a few thousand cycles; this is far beyond that
    initial begin
        #100000;
        bad_count++;
        results();
    end
endmodule // tb

// *** core/fetc_coding_path.sv ***
// 100 Mb/s 4b5b coding, scrambling, nrzi and mlt-3 path with its receive decode
`timescale 1ns/10ps

module fetc_coding_path
    import fetc_pkg::*;
#(
    parameter int BIT_DIV = BIT_DIV_DEF
) (
    input  wire logic               core_clk_i,
    input  wire logic               reset_n_i,
    input  wire logic [STRAP_W-1:0] phy_address_straps_i,
    input  wire fetc_tx_mii_s       tx_mii_i,
    output logic                    tx_nibble_take_o,
    output fetc_mlt_s               tx_mlt_o,
    input  wire fetc_mlt_s          rx_mlt_i,
    input  wire logic               rx_resync_i,
    output fetc_rx_mii_s            rx_mii_o,
    output logic                    rx_nibble_vld_o,
    output logic                    rx_in_frame_o
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] enc_nib(input logic [3:0] nib);
        enc_nib = DATA_CG[nib];
    endfunction

    function automatic fetc_cls_e classify(input logic [4:0] cg);
        classify = CLS_INVALID;
        case (cg)
            CG_IDLE: classify = CLS_IDLE;
            CG_J:    classify = CLS_J;
            CG_K:    classify = CLS_K;
            CG_T:    classify = CLS_T;
            CG_R:    classify = CLS_R;
            CG_HALT: classify = CLS_HALT;
            default: begin
                for (int i = 0; i < 16; i++) begin
                    if (DATA_CG[i] == cg) begin
                        classify = CLS_DATA;
                    end
                end
            end
        endcase
    endfunction

    function automatic logic [3:0] dec_nib(input logic [4:0] cg);
        dec_nib = NIB_ZERO;
        for (int i = 0; i < 16; i++) begin
            if (DATA_CG[i] == cg) begin
                dec_nib = 4'(i);
            end
        end
    endfunction

    // key bit is the feedback; state therefore holds the last eleven key bits
    function automatic logic lfsr_key(input logic [LFSR_W-1:0] s);
        lfsr_key = s[LFSR_TAP_A] ^ s[LFSR_TAP_B];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bit-rate enable: core clock cannot hit 125 MHz exactly, so the line rate is core_clk / BIT_DIV
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       bit_en;

    always_comb begin
        bit_en   = (div_reg == 8'(BIT_DIV - 1));
        div_next = bit_en ? 8'h00 : div_reg + 8'h01;
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit code-group sequencing
    fetc_tx_state_e tx_state_reg;
    fetc_tx_state_e tx_state_next;
    logic [4:0]     tx_sym_reg;
    logic [4:0]     tx_sym_next;
    logic [2:0]     tx_bit_reg;
    logic [2:0]     tx_bit_next;
    logic           sym_end;

    always_comb begin
        tx_state_next    = tx_state_reg;
        tx_sym_next      = tx_sym_reg;
        tx_bit_next      = tx_bit_reg;
        tx_nibble_take_o = 1'b0;
        sym_end          = bit_en && (tx_bit_reg == 3'(SYM_LAST));
        if (bit_en) begin
            tx_bit_next = sym_end ? 3'h0 : tx_bit_reg + 3'h1;
            tx_sym_next = {tx_sym_reg[3:0], 1'b0};
        end
        if (sym_end) begin
            case (tx_state_reg)
                TX_IDLE, TX_R: begin
                    if (tx_mii_i.en) begin
                        tx_state_next    = TX_J;
                        tx_sym_next      = CG_J;
                        tx_nibble_take_o = 1'b1;
                    end else begin
                        tx_state_next = TX_IDLE;
                        tx_sym_next   = CG_IDLE;
                    end
                end
                TX_J: begin
                    // K always follows J; a nibble is consumed only while one is offered
                    tx_state_next    = TX_K;
                    tx_sym_next      = CG_K;
                    tx_nibble_take_o = tx_mii_i.en;
                end
                TX_K, TX_DATA: begin
                    if (tx_mii_i.en) begin
                        tx_state_next    = TX_DATA;
                        tx_sym_next      = enc_nib(tx_mii_i.data);
                        tx_nibble_take_o = 1'b1;
                    end else begin
                        tx_state_next = TX_T;
                        tx_sym_next   = CG_T;
                    end
                end
                TX_T: begin
                    tx_state_next = TX_R;
                    tx_sym_next   = CG_R;
                end
                default: begin
                    tx_state_next = TX_IDLE;
                    tx_sym_next   = CG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            tx_state_reg <= TX_IDLE;
            tx_sym_reg   <= CG_IDLE;
            tx_bit_reg   <= 3'h0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_sym_reg   <= tx_sym_next;
            tx_bit_reg   <= tx_bit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scrambler, nrzi and mlt-3 drive; no bypass path exists
    logic [LFSR_W-1:0] tx_lfsr_reg;
    logic [LFSR_W-1:0] tx_lfsr_next;
    logic              seeded_reg;
    logic              seeded_next;
    logic              nrzi_reg;
    logic              nrzi_next;
    fetc_mlt_e         mlt_reg;
    fetc_mlt_e         mlt_next;
    fetc_mlt_s         mlt_out_reg;
    fetc_mlt_s         mlt_out_next;
    logic              tx_sd;

    always_comb begin
        tx_lfsr_next = tx_lfsr_reg;
        seeded_next  = 1'b1;
        nrzi_next    = nrzi_reg;
        mlt_next     = mlt_reg;
        tx_sd        = tx_sym_reg[SYM_LAST] ^ lfsr_key(tx_lfsr_reg);
        if (!seeded_reg) begin
            // straps caught after reset release; seed never all-zero
            tx_lfsr_next = {phy_address_straps_i, SEED_LOW};
        end else if (bit_en) begin
            tx_lfsr_next = {tx_lfsr_reg[LFSR_W-2:0], lfsr_key(tx_lfsr_reg)};
            nrzi_next = nrzi_reg ^ tx_sd;
            // each nrzi transition steps the three-level state, so ones alternate polarity
            if (nrzi_next != nrzi_reg) begin
                case (mlt_reg)
                    MLT_ZERO_UP: mlt_next = MLT_PLUS;
                    MLT_PLUS:    mlt_next = MLT_ZERO_DN;
                    MLT_ZERO_DN: mlt_next = MLT_MINUS;
                    default:     mlt_next = MLT_ZERO_UP;
                endcase
            end
        end
        mlt_out_next.pos = (mlt_next == MLT_PLUS);
        mlt_out_next.neg = (mlt_next == MLT_MINUS);
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            tx_lfsr_reg <= '1;
            seeded_reg  <= 1'b0;
            nrzi_reg    <= 1'b0;
            mlt_reg     <= MLT_ZERO_UP;
            mlt_out_reg <= '0;
        end else begin
            tx_lfsr_reg <= tx_lfsr_next;
            seeded_reg  <= seeded_next;
            nrzi_reg    <= nrzi_next;
            mlt_reg     <= mlt_next;
            mlt_out_reg <= mlt_out_next;
        end
    end

    assign tx_mlt_o = mlt_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // receive: mlt-3 level change is a one; descramble, align on J/K, decode
    fetc_mlt_s         rx_lvl_reg;
    fetc_mlt_s         rx_lvl_next;
    logic [LFSR_W-1:0] rx_sd_hist_reg;
    logic [LFSR_W-1:0] rx_sd_hist_next;
    logic [LFSR_W-1:0] rx_lfsr_reg;
    logic [LFSR_W-1:0] rx_lfsr_next;
    logic [9:0]        rx_ud_reg;
    logic [9:0]        rx_ud_next;
    logic [2:0]        rx_bit_reg;
    logic [2:0]        rx_bit_next;
    logic              in_frame_reg;
    logic              in_frame_next;
    logic              t_seen_reg;
    logic              t_seen_next;
    fetc_rx_mii_s      rx_mii_reg;
    fetc_rx_mii_s      rx_mii_next;
    logic              rx_vld_reg;
    logic              rx_vld_next;
    logic              rx_sd;
    logic              rx_ud;
    logic [9:0]        ud_now;
    fetc_cls_e         cls;

    always_comb begin
        rx_lvl_next     = rx_lvl_reg;
        rx_sd_hist_next = rx_sd_hist_reg;
        rx_lfsr_next    = rx_lfsr_reg;
        rx_ud_next      = rx_ud_reg;
        rx_bit_next     = rx_bit_reg;
        in_frame_next   = in_frame_reg;
        t_seen_next     = t_seen_reg;
        rx_mii_next     = rx_mii_reg;
        rx_vld_next     = 1'b0;
        rx_sd           = (rx_mlt_i != rx_lvl_reg);
        rx_ud           = rx_sd ^ lfsr_key(rx_lfsr_reg);
        ud_now          = {rx_ud_reg[8:0], rx_ud};
        cls             = classify(ud_now[4:0]);
        if (bit_en) begin
            rx_lvl_next     = rx_mlt_i;
            rx_sd_hist_next = {rx_sd_hist_reg[LFSR_W-2:0], rx_sd};
            rx_lfsr_next    = {rx_lfsr_reg[LFSR_W-2:0], lfsr_key(rx_lfsr_reg)};
            rx_ud_next      = ud_now;
            rx_bit_next     = (rx_bit_reg == 3'(SYM_LAST)) ? 3'h0 : rx_bit_reg + 3'h1;
            if (!in_frame_reg) begin
                if (ud_now == {CG_J, CG_K}) begin
                    in_frame_next = 1'b1;
                    t_seen_next   = 1'b0;
                    rx_bit_next   = 3'h0;
                    rx_vld_next   = 1'b1;
                    rx_mii_next   = '{dv: 1'b1, er: 1'b0, data: NIB_SSD};
                end
            end else if (rx_bit_reg == 3'(SYM_LAST)) begin
                rx_vld_next = 1'b1;
                rx_mii_next = '{dv: 1'b1, er: 1'b0, data: NIB_ZERO};
                t_seen_next = 1'b0;
                case (cls)
                    CLS_DATA: begin
                        rx_mii_next.data = dec_nib(ud_now[4:0]);
                        rx_mii_next.er   = t_seen_reg;
                    end
                    CLS_T: begin
                        t_seen_next = 1'b1;
                    end
                    CLS_R: begin
                        rx_mii_next.er = !t_seen_reg;
                        in_frame_next  = !t_seen_reg;
                        rx_mii_next.dv = !t_seen_reg;
                    end
                    CLS_IDLE: begin
                        rx_mii_next.er = 1'b1;
                        in_frame_next  = 1'b0;
                    end
                    CLS_J, CLS_K: begin
                        rx_mii_next.er   = 1'b1;
                        rx_mii_next.data = NIB_SSD;
                    end
                    default: begin
                        rx_mii_next.er = 1'b1;
                    end
                endcase
            end
        end
        if (rx_resync_i) begin
            // line idle: plaintext all ones, so key history is the inverted line;
            // the bit arriving now is folded in so the key stays in step with the line
            rx_lfsr_next = ~rx_sd_hist_next;
        end
        if (!in_frame_next && !rx_vld_next) begin
            rx_mii_next = '{dv: 1'b0, er: 1'b0, data: NIB_ZERO};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rx_lvl_reg     <= '0;
            rx_sd_hist_reg <= '0;
            rx_lfsr_reg    <= '1;
            rx_ud_reg      <= '0;
            rx_bit_reg     <= 3'h0;
            in_frame_reg   <= 1'b0;
            t_seen_reg     <= 1'b0;
            rx_mii_reg     <= '0;
            rx_vld_reg     <= 1'b0;
        end else begin
            rx_lvl_reg     <= rx_lvl_next;
            rx_sd_hist_reg <= rx_sd_hist_next;
            rx_lfsr_reg    <= rx_lfsr_next;
            rx_ud_reg      <= rx_ud_next;
            rx_bit_reg     <= rx_bit_next;
            in_frame_reg   <= in_frame_next;
            t_seen_reg     <= t_seen_next;
            rx_mii_reg     <= rx_mii_next;
            rx_vld_reg     <= rx_vld_next;
        end
    end

    assign rx_mii_o        = rx_mii_reg;
    assign rx_nibble_vld_o = rx_vld_reg;
    assign rx_in_frame_o   = in_frame_reg;

endmodule // fetc_coding_path

// *** core/fetc_pkg.sv ***
// shared constants, code-groups and carriers for the 100 Mb/s coding path
package fetc_pkg;

    localparam int       SYM_W      = 5;
    localparam int       NIB_W      = 4;
    localparam int       LFSR_W     = 11;
    localparam int       STRAP_W    = 5;
    localparam int       LFSR_TAP_A = 10;
    localparam int       LFSR_TAP_B = 8;
    localparam int       SYM_LAST   = 4;
    localparam int       BIT_DIV_DEF = 2;

    // control code-groups
    localparam logic [4:0] CG_IDLE = 5'h1f;
    localparam logic [4:0] CG_J    = 5'h18;
    localparam logic [4:0] CG_K    = 5'h11;
    localparam logic [4:0] CG_T    = 5'h0d;
    localparam logic [4:0] CG_R    = 5'h07;
    localparam logic [4:0] CG_HALT = 5'h04;

    localparam logic [3:0] NIB_SSD  = 4'h5;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [5:0] SEED_LOW = 6'h01;

    // data code-groups indexed by nibble
    localparam logic [4:0] DATA_CG [16] = '{
        5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
    };

    typedef enum {
        CLS_DATA, CLS_IDLE, CLS_J, CLS_K, CLS_T, CLS_R, CLS_HALT, CLS_INVALID
    } fetc_cls_e;

    typedef enum {
        TX_IDLE, TX_J, TX_K, TX_DATA, TX_T, TX_R
    } fetc_tx_state_e;

    typedef enum {
        MLT_ZERO_UP, MLT_PLUS, MLT_ZERO_DN, MLT_MINUS
    } fetc_mlt_e;

    typedef struct packed {
        logic       en;
        logic [3:0] data;
    } fetc_tx_mii_s;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] data;
    } fetc_rx_mii_s;

    typedef struct packed {
        logic pos;
        logic neg;
    } fetc_mlt_s;

endpackage
